// ===== hdl/gpio_pkg.sv
// Purpose: Shared constants and types for the two-pin port pair.
// Assumes: Registers sit one per 32-bit word; byte address is index * 4.
// Notes: Port latches have no reset value; every other register is reset.
package gpio_pkg;

  // Pin count of each port
  localparam int PORT_W = 2;

  // Register indices, byte address is four times the index
  localparam logic [5:0] FIRST_LATCH_IDX = 6'h03;
  localparam logic [5:0] SECOND_LATCH_IDX = 6'h08;
  localparam logic [5:0] FIRST_DIR_IDX = 6'h07;
  localparam logic [5:0] SECOND_DIR_IDX = 6'h0C;
  localparam logic [5:0] OPTION_IDX = 6'h1F;

  // Field positions inside the option register
  localparam int OPT_SERIAL_ALT_BIT = 0;

  // Reset values of control registers
  localparam logic [1:0] DIR_RESET = 2'h0;
  localparam logic OPT_RESET = 1'h0;

  // Serial pin positions on the second port
  localparam int SERIAL_TX_BIT = 0;
  localparam int SERIAL_RX_BIT = 1;

  // Avalon-MM response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Output level and output enable of a group of pins
  typedef struct packed {
    logic [1:0] dout;
    logic [1:0] oe;
  } pin_drive_t;

endpackage

// ===== hdl/pin_sampler.sv
// Purpose: Registers every input pin once on the bus clock.
// Assumes: Pin inputs are already synchronous to ref_clk.
// Notes: Sampled values feed reads and the shared peripherals.
`timescale 1ns/1ns
module pin_sampler #(
  parameter int W = 5
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Raw pin levels and their registered copy
  input wire logic [W-1:0] pins_in,
  output logic [W-1:0] sampled_r
);

  // Width must be usable
  initial begin
    if (W < 1) begin
      $error("pin_sampler: W must be at least 1");
    end
  end

  // One sampling flop per pin
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          sampled_r[i] <= 1'b0;
        end else begin
          sampled_r[i] <= pins_in[i];
        end
      end
    end
  endgenerate

endmodule

// ===== hdl/port_pair_gpio.sv
// Purpose: Two 2-pin bidirectional ports behind an Avalon-MM slave.
// Assumes: Timer and serial units hand over their pin needs as inputs.
// Notes: Every answer takes one wait cycle; outputs are all registered.
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ns
module port_pair_gpio
  import gpio_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Avalon-MM slave, byte addressed
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic [1:0] response,
  output logic waitrequest,
  // First port pins
  input wire logic [1:0] first_pin_in,
  output pin_drive_t first_pins,
  // Second port pins
  input wire logic [1:0] second_pin_in,
  output pin_drive_t second_pins,
  // Timer unit sharing the first port
  input wire pin_drive_t timer_drive,
  output logic [1:0] timer_capture,
  // Serial unit sharing the second port
  input wire logic serial_en,
  input wire logic serial_tx,
  output logic serial_rx,
  // Alternative serial pins on the first bank
  input wire logic alt_receive_pin,
  output logic alt_transmit_pin,
  output logic alt_transmit_oe
);

  // Address must hold the highest register index
  initial begin
    if (ADDR_W < 8 || ADDR_W > 16) begin
      $error("port_pair_gpio: ADDR_W must be 8 to 16");
    end
  end

  // Assertions below sample on the rising clock, quiet in reset
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // Data latches, never reset
  logic [1:0] first_port_latch;
  logic [1:0] second_port_latch;
  // Direction registers, 1 means output
  logic [1:0] first_port_direction;
  logic [1:0] second_port_direction;
  // Option bit moving the serial pins
  logic serial_alt_r;
  // Registered pin levels of each group
  logic [1:0] first_samp;
  logic [1:0] second_samp;
  logic alt_rx_samp;
  // Bus handshake state and decode
  logic wait_r;
  logic req;
  logic [5:0] idx;
  logic hit;
  logic lo_we;
  // Registered outputs
  logic [31:0] readdata_r;
  logic [1:0] response_r;
  pin_drive_t first_pins_r;
  pin_drive_t second_pins_r;
  logic [1:0] timer_capture_r;
  logic serial_rx_r;
  logic alt_tx_r;
  logic alt_oe_r;
  // Serial unit owns pins in place or on alternates
  logic serial_home;
  logic serial_away;
  // Read values before registering
  logic [1:0] first_view;
  logic [1:0] second_view;
  logic [31:0] read_nxt;

  // Pin sampling stage, split straight into the three groups
  pin_sampler #(.W(5)) u_sampler (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pins_in({alt_receive_pin, second_pin_in, first_pin_in}),
    .sampled_r({alt_rx_samp, second_samp, first_samp})
  );

  // Request decode; only aligned words with a known index hit
  assign req = read | write;
  assign idx = address[7:2];
  assign lo_we = write & ~wait_r & byteenable[0] & hit;
  assign hit = (address[1:0] == 2'h0) &&
               (address[ADDR_W-1:2] == (ADDR_W-2)'(idx)) &&
               (idx inside {FIRST_LATCH_IDX, SECOND_LATCH_IDX,
                            FIRST_DIR_IDX, SECOND_DIR_IDX, OPTION_IDX});

  // Serial ownership of pins
  assign serial_home = serial_en & ~serial_alt_r;
  assign serial_away = serial_en & serial_alt_r;

  // Per-pin read view: latch where output, pin level where input
  assign first_view = (first_port_latch & first_port_direction) |
                      (first_samp & ~first_port_direction);
  assign second_view = (second_port_latch & second_port_direction) |
                       (second_samp & ~second_port_direction);

  // Read mux; unmapped words read as zero
  always_comb begin
    read_nxt = 32'h0000_0000;
    case (idx)
      FIRST_LATCH_IDX: read_nxt[1:0] = first_view;
      SECOND_LATCH_IDX: read_nxt[1:0] = second_view;
      FIRST_DIR_IDX: read_nxt[1:0] = first_port_direction;
      SECOND_DIR_IDX: read_nxt[1:0] = second_port_direction;
      OPTION_IDX: read_nxt[OPT_SERIAL_ALT_BIT] = serial_alt_r;
      default: read_nxt = 32'h0000_0000;
    endcase
  end

  // Waitrequest: high at rest, low for one cycle per request
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= ~(req & wait_r);
    end
  end

  // Read data and response, captured in the first request cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata_r <= 32'h0000_0000;
      response_r <= RESP_OKAY;
    end else if (req && wait_r) begin
      readdata_r <= (read && hit) ? read_nxt : 32'h0000_0000;
      response_r <= hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Data latches: no reset, written whatever the direction
  always_ff @(posedge ref_clk) begin
    if (lo_we && idx == FIRST_LATCH_IDX) begin
      first_port_latch <= writedata[1:0];
    end
    if (lo_we && idx == SECOND_LATCH_IDX) begin
      second_port_latch <= writedata[1:0];
    end
  end

  // Direction registers come up as inputs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_port_direction <= DIR_RESET;
      second_port_direction <= DIR_RESET;
    end else begin
      if (lo_we && idx == FIRST_DIR_IDX) begin
        first_port_direction <= writedata[1:0];
      end
      if (lo_we && idx == SECOND_DIR_IDX) begin
        second_port_direction <= writedata[1:0];
      end
    end
  end

  // Option register selecting the serial pin placement
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_alt_r <= OPT_RESET;
    end else if (lo_we && idx == OPTION_IDX) begin
      serial_alt_r <= writedata[OPT_SERIAL_ALT_BIT];
    end
  end

  // First port drivers; an enabled timer channel takes its pin
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_pins_r <= '0;
      timer_capture_r <= 2'h0;
    end else begin
      first_pins_r.oe <= first_port_direction | timer_drive.oe;
      first_pins_r.dout <= (timer_drive.dout & timer_drive.oe) |
                           (first_port_latch & ~timer_drive.oe);
      timer_capture_r <= first_samp;
    end
  end

  // Second port drivers; the serial unit takes both pins in place
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      second_pins_r <= '0;
    end else begin
      second_pins_r.oe <= second_port_direction;
      second_pins_r.dout <= second_port_latch;
      if (serial_home) begin
        second_pins_r.oe[SERIAL_TX_BIT] <= 1'b1;
        second_pins_r.dout[SERIAL_TX_BIT] <= serial_tx;
        second_pins_r.oe[SERIAL_RX_BIT] <= 1'b0;
      end
    end
  end

  // Serial receive source and alternative transmit pin
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_rx_r <= 1'b1;
      alt_tx_r <= 1'b1;
      alt_oe_r <= 1'b0;
    end else begin
      if (serial_away) begin
        serial_rx_r <= alt_rx_samp;
      end else if (serial_home) begin
        serial_rx_r <= second_samp[SERIAL_RX_BIT];
      end else begin
        serial_rx_r <= 1'b1;
      end
      alt_tx_r <= serial_away ? serial_tx : 1'b1;
      alt_oe_r <= serial_away;
    end
  end

  // Outputs straight from flops
  assign readdata = readdata_r;
  assign response = response_r;
  assign waitrequest = wait_r;
  assign first_pins = first_pins_r;
  assign second_pins = second_pins_r;
  assign timer_capture = timer_capture_r;
  assign serial_rx = serial_rx_r;
  assign alt_transmit_pin = alt_tx_r;
  assign alt_transmit_oe = alt_oe_r;

  // Marks the first cycle after reset release
  logic fresh_r;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fresh_r <= 1'b1;
    end else begin
      fresh_r <= 1'b0;
    end
  end

  // First port floats every pin with direction 0 and no timer
  a_first_oe_dir: assert property (
    !fresh_r |=> first_pins.oe ==
      $past(first_port_direction | timer_drive.oe))
    else $error("first port enable does not follow direction");

  // Second port enable follows direction when serial is idle
  a_second_oe_dir: assert property (
    !serial_home |=> second_pins.oe == $past(second_port_direction))
    else $error("second port enable does not follow direction");

  // Directions are clear right after reset
  a_first_dir_reset: assert property (
    fresh_r |-> first_port_direction == 2'h0 && first_pins.oe == 2'h0)
    else $error("first port direction not cleared by reset");

  a_second_dir_reset: assert property (
    fresh_r |-> second_port_direction == 2'h0 && second_pins.oe == 2'h0)
    else $error("second port direction not cleared by reset");

  // Output pins read back the latch
  a_first_read_out: assert property (
    (read && wait_r && hit && idx == FIRST_LATCH_IDX) |=>
      (readdata[1:0] & $past(first_port_direction)) ==
      ($past(first_port_latch) & $past(first_port_direction)))
    else $error("first port read of output pin not latch");

  // Input pins read back the sampled level
  a_first_read_in: assert property (
    (read && wait_r && hit && idx == FIRST_LATCH_IDX) |=>
      (readdata[1:0] & ~$past(first_port_direction)) ==
      ($past(first_samp) & ~$past(first_port_direction)))
    else $error("first port read of input pin not pin level");

  a_second_read_out: assert property (
    (read && wait_r && hit && idx == SECOND_LATCH_IDX) |=>
      (readdata[1:0] & $past(second_port_direction)) ==
      ($past(second_port_latch) & $past(second_port_direction)))
    else $error("second port read of output pin not latch");

  a_second_read_in: assert property (
    (read && wait_r && hit && idx == SECOND_LATCH_IDX) |=>
      (readdata[1:0] & ~$past(second_port_direction)) ==
      ($past(second_samp) & ~$past(second_port_direction)))
    else $error("second port read of input pin not pin level");

  // A completed second port latch write lands whatever the direction
  a_latch_write: assert property (
    (lo_we && idx == SECOND_LATCH_IDX) |=>
      second_port_latch == $past(writedata[1:0]))
    else $error("second port latch write lost");

  // Alternate placement routes transmit to the alternate pin
  a_serial_alt_tx: assert property (
    (serial_en && serial_alt_r) |=>
      alt_transmit_oe && alt_transmit_pin == $past(serial_tx))
    else $error("alternate transmit pin not driven by serial");

  // Home placement puts transmit on the second port bit 0
  a_serial_home_tx: assert property (
    (serial_en && !serial_alt_r) |=>
      second_pins.oe[0] && !second_pins.oe[1] &&
      second_pins.dout[0] == $past(serial_tx))
    else $error("serial transmit not on second port bit 0");

  // An enabled timer channel 0 drives first port pin 0
  a_timer_takes_pin: assert property (
    timer_drive.oe[0] |=>
      first_pins.oe[0] && first_pins.dout[0] == $past(timer_drive.dout[0]))
    else $error("timer channel does not own first port pin");

  // Every request is answered on the next cycle
  a_bus_answer: assert property (
    (req && wait_r) |=> !waitrequest)
    else $error("request not answered in one wait cycle");

endmodule

// ===== verif/pin_partner.sv
// Purpose: Outside world on the two port pin pairs.
// Assumes: Undriven pins are held by an outside driver at ext levels.
// Notes: A pin the block drives reads back as the block's level.
`timescale 1ns/1ns
module pin_partner
  import gpio_pkg::*;
(
  // Drive from the block
  input wire pin_drive_t first_pins,
  input wire pin_drive_t second_pins,
  // Outside levels on floating pins
  input wire logic [1:0] first_ext,
  input wire logic [1:0] second_ext,
  // Resolved wire levels
  output logic [1:0] first_pin_in,
  output logic [1:0] second_pin_in
);
  // Driven bits follow the block, floating bits the outside
  assign first_pin_in = (first_pins.oe & first_pins.dout) |
    (~first_pins.oe & first_ext);
  assign second_pin_in = (second_pins.oe & second_pins.dout) |
    (~second_pins.oe & second_ext);
endmodule

// ===== verif/tb.sv
// Purpose: Self-checking bench for the two-pin port pair.
// Assumes: One wait cycle per bus answer; latches unknown until written.
// Notes: Reads are noted in a queue and checked by a monitor.
`timescale 1ns/1ns
module tb;
  import gpio_pkg::*;
  // Clock, reset and bus
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata;
  logic [1:0] response;
  logic waitrequest;
  // Pins and shared units
  logic [1:0] first_pin_in, second_pin_in, timer_capture;
  pin_drive_t first_pins, second_pins;
  pin_drive_t timer_drive = 4'h0;
  logic serial_en = 1'b0;
  logic serial_tx = 1'b1;
  logic alt_receive_pin = 1'b1;
  logic serial_rx, alt_transmit_pin, alt_transmit_oe;
  logic [1:0] first_ext = 2'h0;
  logic [1:0] second_ext = 2'h0;
  // Expected read results and counters
  logic [31:0] exp_d_q[$];
  logic [1:0] exp_r_q[$];
  logic [31:0] exp_d;
  int n_mismatch = 0;
  int total_checks = 0;
  // Random source, seed 98965
  logic [31:0] lfsr = 32'h00018295;

  always #20 ref_clk = ~ref_clk;

  port_pair_gpio #(.ADDR_W(8)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .response(response), .waitrequest(waitrequest),
    .first_pin_in(first_pin_in), .first_pins(first_pins),
    .second_pin_in(second_pin_in), .second_pins(second_pins),
    .timer_drive(timer_drive), .timer_capture(timer_capture),
    .serial_en(serial_en), .serial_tx(serial_tx), .serial_rx(serial_rx),
    .alt_receive_pin(alt_receive_pin),
    .alt_transmit_pin(alt_transmit_pin),
    .alt_transmit_oe(alt_transmit_oe));

  pin_partner far_side (.first_pins(first_pins), .second_pins(second_pins),
    .first_ext(first_ext), .second_ext(second_ext),
    .first_pin_in(first_pin_in), .second_pin_in(second_pin_in));

  // Next random word
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Byte address of a register index
  function automatic logic [7:0] ba(input logic [5:0] idx);
    return {idx, 2'b00};
  endfunction

  // One comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Hold the request until waitrequest is seen low
  task automatic bus_wait();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      $display("Error at %0t: no bus answer", $time);
    end
  endtask

  // Register write, response noted for the monitor
  task automatic bus_wr(input logic [7:0] a, input logic [1:0] d,
    input logic [1:0] r = RESP_OKAY);
    exp_d_q.push_back(32'h0);
    exp_r_q.push_back(r);
    @(posedge ref_clk);
    address <= a;
    writedata <= 32'(d);
    write <= 1'b1;
    bus_wait();
    write <= 1'b0;
  endtask

  // Register read, result noted for the monitor
  task automatic bus_rd(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r);
    exp_d_q.push_back(d);
    exp_r_q.push_back(r);
    @(posedge ref_clk);
    address <= a;
    read <= 1'b1;
    bus_wait();
    read <= 1'b0;
  endtask

  // Let n edges pass, then settle
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask

  // Verdict and end of run
  task automatic wrap_up();
    if (exp_d_q.size() != 0) begin
      n_mismatch++;
      $display("Error at %0t: bus answers missing", $time);
    end
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Monitor takes the oldest note at each read or write answer
  always @(posedge ref_clk) begin
    if ((read === 1'b1 || write === 1'b1) && waitrequest === 1'b0) begin
      if (exp_d_q.size() == 0) begin
        n_mismatch++;
        $display("Error at %0t: bus answer not expected", $time);
      end else begin
        exp_d = exp_d_q.pop_front();
        if (read === 1'b1) begin
          chk(readdata, exp_d, "readdata");
        end
        chk(32'(response), 32'(exp_r_q.pop_front()), "response");
      end
    end
  end

  // Hang guard
  initial begin
    #200000;
    n_mismatch++;
    $display("Error at %0t: watchdog expired", $time);
    wrap_up();
  end

  // Main sequence
  initial begin
    logic [1:0] dr1, dr2, lt1, lt2, e1, e2;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    // Directions come up cleared, pins float
    bus_rd(ba(FIRST_DIR_IDX), 32'h0, RESP_OKAY);
    bus_rd(ba(SECOND_DIR_IDX), 32'h0, RESP_OKAY);
    chk(32'({first_pins.oe, second_pins.oe}), 32'h0, "oe");
    // Unmapped and unaligned places give an error and zero
    bus_rd(8'h04, 32'h0, RESP_SLVERR);
    bus_rd(ba(FIRST_LATCH_IDX) + 8'h01, 32'h0, RESP_SLVERR);
    bus_wr(8'h04, 2'h3, RESP_SLVERR);
    // Random mixes of direction, latch and outside level
    for (int i = 0; i < 8; i++) begin
      repeat (12) lfsr = lfsr_next(lfsr);
      {dr1, dr2, lt1, lt2, e1, e2} = lfsr[11:0];
      @(posedge ref_clk);
      first_ext <= e1;
      second_ext <= e2;
      bus_wr(ba(FIRST_LATCH_IDX), lt1);
      bus_wr(ba(SECOND_LATCH_IDX), lt2);
      bus_wr(ba(FIRST_DIR_IDX), dr1);
      bus_wr(ba(SECOND_DIR_IDX), dr2);
      idle(3);
      chk(32'(first_pins.oe), 32'(dr1), "first oe");
      chk(32'(second_pins.oe), 32'(dr2), "second oe");
      chk(32'(first_pins.dout & dr1), 32'(lt1 & dr1), "first dout");
      chk(32'(second_pins.dout & dr2), 32'(lt2 & dr2), "dout");
      bus_rd(ba(FIRST_DIR_IDX), 32'(dr1), RESP_OKAY);
      bus_rd(ba(FIRST_LATCH_IDX), 32'((dr1 & lt1) | (~dr1 & e1)),
        RESP_OKAY);
      bus_rd(ba(SECOND_LATCH_IDX), 32'((dr2 & lt2) | (~dr2 & e2)),
        RESP_OKAY);
    end
    // Reset in mid-run keeps latches, clears directions
    @(posedge ref_clk);
    rst_n <= 1'b0;
    idle(2);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    idle(1);
    chk(32'({first_pins.oe, second_pins.oe}), 32'h0, "oe");
    bus_wr(ba(FIRST_DIR_IDX), 2'h3);
    bus_wr(ba(SECOND_DIR_IDX), 2'h3);
    bus_rd(ba(FIRST_LATCH_IDX), 32'(lt1), RESP_OKAY);
    bus_rd(ba(SECOND_LATCH_IDX), 32'(lt2), RESP_OKAY);
    bus_wr(ba(FIRST_DIR_IDX), 2'h0);
    bus_wr(ba(SECOND_DIR_IDX), 2'h0);
    // Timer takes pin 0 of the first port
    @(posedge ref_clk);
    timer_drive <= 4'h5;
    first_ext <= 2'h2;
    idle(4);
    chk(32'({first_pins.dout[0], first_pins.oe}), 32'h5, "timer");
    chk(32'(timer_capture), 32'h3, "capture");
    // Serial unit on its home pins
    @(posedge ref_clk);
    timer_drive <= 4'h0;
    serial_en <= 1'b1;
    serial_tx <= 1'b0;
    second_ext <= 2'h1;
    idle(3);
    chk(32'({second_pins.oe, second_pins.dout[0]}), 32'h2, "tx");
    chk(32'(serial_rx), 32'h0, "rx home");
    // Serial unit moved to the alternate pins
    @(posedge ref_clk);
    alt_receive_pin <= 1'b0;
    second_ext <= 2'h2;
    bus_wr(ba(OPTION_IDX), 2'h1);
    idle(3);
    chk(32'({alt_transmit_oe, alt_transmit_pin, serial_rx,
      second_pins.oe}), 32'h10, "alt");
    wrap_up();
  end
endmodule
